// >>> rtl/pmicps_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "pmicps_regs.vh"
// power state controller: fuse load, off states, self-test, power-up, run
module pmicps_ctrl #(
  parameter NSW = 7,
  parameter NLDO = 4,
  parameter NSTEP = 12,
  parameter FUSE_WORDS = 32,
  parameter RETRY_CYC = `PMICPS_RETRY_CYC,
  parameter STEP_CYC = 100
) (
  input wire clock,
  input wire srst,
  input wire digital_rail_ok,
  input wire analog_rail_ok,
  input wire input_above_uv,
  input wire coin_cell_valid,
  input wire power_on_pin,
  input wire fuse_program_supply,
  input wire io_supply,
  input wire [7:0] fuse_data,
  input wire fuse_crc_ok,
  input wire fuse_trim_word_done,
  input wire fuse_word_is_trim,
  input wire fuse_load_done,
  input wire [1:0] fuse_always_on_cfg,
  input wire fuse_power_on_mode,
  input wire fuse_sync_input_enable,
  input wire fuse_sync_output_enable,
  input wire fuse_spread_spectrum_enable,
  input wire fuse_switcher_mode,
  input wire [NSW*8-1:0] fuse_switcher_voltage,
  input wire [NLDO*4-1:0] fuse_linear_voltage,
  input wire [4:0] fuse_switcher_seven_voltage,
  input wire [NSW-1:0] fuse_switcher_in_seq,
  input wire [NLDO-1:0] fuse_linear_in_seq,
  input wire [NSTEP*4-1:0] fuse_step_slot,
  input wire [3:0] fuse_reset_slot,
  input wire [3:0] fuse_power_good_out_slot,
  input wire fuse_power_good_out_is_gpo,
  input wire self_test_present,
  input wire clock_in_tol,
  input wire bandgaps_agree,
  input wire mirror_crc_ok,
  input wire [3:0] monitor_test_fail,
  input wire test_done,
  input wire trial_config_mode,
  input wire low_power_off_wr,
  input wire low_power_off_wdata,
  input wire backup_charger_wr,
  input wire backup_charger_wdata,
  input wire mirror_wr,
  input wire [4:0] mirror_addr,
  input wire [7:0] mirror_wdata,
  output reg [7:0] mirror_rdata,
  output reg mirror_access_ok,
  output reg [3:0] state,
  output reg trim_load_error,
  output reg fuse_load_error,
  output reg self_test_error,
  output reg [3:0] monitor_test_flag,
  output reg fuse_to_functional,
  output reg [1:0] always_on_cfg,
  output reg low_power_off_select,
  output reg charger_on,
  output reg internal_bias_on,
  output reg test_start,
  output reg failsafe_req,
  output reg [NSW-1:0] switcher_enable,
  output reg [NLDO-1:0] linear_enable,
  output reg power_good_out,
  output reg host_reset_out,
  output reg [NSW*8-1:0] switcher_run_voltage,
  output reg [NSW*2-1:0] switcher_run_mode,
  output reg [NLDO*4-1:0] linear_run_voltage,
  output reg [NLDO-1:0] linear_run_enable,
  output reg [4:0] switcher_seven_voltage
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  wire [4:0] pins_s;
  pmicps_sync #(.W(5)) u_sync (
    .clock(clock),
    .srst(srst),
    .async_in({power_on_pin, input_above_uv, coin_cell_valid,
      digital_rail_ok & analog_rail_ok, io_supply}),
    .sync_out(pins_s)
  );
  wire power_on_pin_s = pins_s[4];
  wire vin_ok = pins_s[3];
  wire coin_ok = pins_s[2];
  wire rails_ok = pins_s[1];
  wire io_ok = pins_s[0];
  reg power_on_pin_d_r;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function [1:0] run_mode_default;
    input in_seq;
    input sync_in;
    input sync_out;
    input fss;
    input swmode;
    begin
      if (!in_seq) run_mode_default = `PMICPS_MODE_OFF;
      else if (sync_in | sync_out | fss) run_mode_default = `PMICPS_MODE_PWM;
      else if (swmode) run_mode_default = `PMICPS_MODE_PWM;
      else run_mode_default = `PMICPS_MODE_AUTO;
    end
  endfunction

  // ---------------------------------------------------------------
  // mirror store
  // ---------------------------------------------------------------
  reg [4:0] load_addr_r;
  wire host_mirror = (state == `PMICPS_ST_QPOFF) && io_ok;
  wire load_we = (state == `PMICPS_ST_LOAD) && rails_ok && !fuse_load_done;
  wire [7:0] mirror_q;
  pmicps_mirror #(.AW(5), .DW(8)) u_mirror (
    .clock(clock),
    .we(load_we | (host_mirror & mirror_wr)),
    .waddr(load_we ? load_addr_r : mirror_addr),
    .wdata(load_we ? fuse_data : mirror_wdata),
    .raddr(mirror_addr),
    .rdata(mirror_q)
  );

  // ---------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------
  // edge mode: power-up event is high-to-low of the pin
  wire pu_event = fuse_power_on_mode ? (power_on_pin_d_r & ~power_on_pin_s) : power_on_pin_s;
  wire load_err = trim_load_error | fuse_load_error;
  localparam [3:0] LAST_SLOT = NSTEP - 1;
  reg [1:0] runs_r;
  reg [31:0] wait_r;
  reg [31:0] step_cnt_r;
  reg [3:0] slot_r;
  reg [3:0] state_nxt;
  integer k;

  always @* begin
    state_nxt = state;
    case (state)
      `PMICPS_ST_COIN: begin
        if (vin_ok) state_nxt = `PMICPS_ST_LOAD;
      end
      `PMICPS_ST_LOAD: begin
        // a failed load still parks in low power off, flags block power-up
        if (rails_ok && fuse_load_done)
          state_nxt = `PMICPS_ST_LPOFF;
      end
      `PMICPS_ST_LPOFF: begin
        if (pu_event && !load_err)
          state_nxt = self_test_present ? `PMICPS_ST_TEST : `PMICPS_ST_QPOFF;
        else if (low_power_off_select && !pu_event)
          state_nxt = self_test_present ? `PMICPS_ST_TEST : `PMICPS_ST_QPOFF;
      end
      `PMICPS_ST_TEST: begin
        if (test_done) begin
          if (clock_in_tol && bandgaps_agree && mirror_crc_ok)
            state_nxt = `PMICPS_ST_QPOFF;
          else if (runs_r + 2'd1 < `PMICPS_SELF_TEST_RUNS)
            state_nxt = `PMICPS_ST_WAIT;
          else if (!trial_config_mode)
            state_nxt = `PMICPS_ST_FSAFE;
          else
            state_nxt = `PMICPS_ST_QPOFF;
        end
      end
      `PMICPS_ST_WAIT: begin
        if (wait_r == RETRY_CYC - 1) state_nxt = `PMICPS_ST_TEST;
      end
      `PMICPS_ST_QPOFF: begin
        if (pu_event && !load_err && !self_test_error)
          state_nxt = `PMICPS_ST_PWRUP;
      end
      `PMICPS_ST_PWRUP: begin
        if (slot_r == LAST_SLOT && step_cnt_r == STEP_CYC - 1)
          state_nxt = `PMICPS_ST_RUN;
      end
      `PMICPS_ST_RUN: begin
        state_nxt = `PMICPS_ST_RUN;
      end
      `PMICPS_ST_FSAFE: begin
        state_nxt = `PMICPS_ST_FSAFE;
      end
      default: state_nxt = `PMICPS_ST_LOAD;
    endcase
    if (!vin_ok) state_nxt = `PMICPS_ST_COIN;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always @(posedge clock) begin
    if (srst || !vin_ok) begin
      state <= `PMICPS_ST_COIN;
      power_on_pin_d_r <= 1'b0;
      load_addr_r <= 5'h00;
      runs_r <= 2'd0;
      wait_r <= 32'h0;
      step_cnt_r <= 32'h0;
      slot_r <= 4'h0;
      trim_load_error <= 1'b0;
      fuse_load_error <= 1'b0;
      self_test_error <= 1'b0;
      monitor_test_flag <= 4'h0;
      fuse_to_functional <= 1'b0;
      always_on_cfg <= 2'b00;
      low_power_off_select <= 1'b0;
      charger_on <= 1'b0;
      internal_bias_on <= 1'b0;
      test_start <= 1'b0;
      failsafe_req <= 1'b0;
      switcher_enable <= {NSW{1'b0}};
      linear_enable <= {NLDO{1'b0}};
      power_good_out <= 1'b0;
      host_reset_out <= 1'b0;
      switcher_run_voltage <= {NSW*8{1'b0}};
      switcher_run_mode <= {NSW*2{1'b0}};
      linear_run_voltage <= {NLDO*4{1'b0}};
      linear_run_enable <= {NLDO{1'b0}};
      switcher_seven_voltage <= 5'h00;
      mirror_rdata <= 8'h00;
      mirror_access_ok <= 1'b0;
    end else begin
      state <= state_nxt;
      power_on_pin_d_r <= power_on_pin_s;
      mirror_rdata <= mirror_q;
      mirror_access_ok <= host_mirror;
      test_start <= (state_nxt == `PMICPS_ST_TEST) &&
        (state != `PMICPS_ST_TEST);
      failsafe_req <= (state == `PMICPS_ST_FSAFE);
      internal_bias_on <= (state_nxt != `PMICPS_ST_LPOFF) &&
        (state_nxt != `PMICPS_ST_LOAD);
      if (state == `PMICPS_ST_LOAD && rails_ok) begin
        if (load_we) load_addr_r <= load_addr_r + 5'h01;
        fuse_to_functional <= fuse_program_supply;
        if (fuse_load_done && !fuse_crc_ok) begin
          if (fuse_word_is_trim) trim_load_error <= 1'b1;
          else fuse_load_error <= 1'b1;
        end
        if (fuse_load_done && fuse_crc_ok && !load_err)
          always_on_cfg <= fuse_always_on_cfg;
      end
      if (low_power_off_wr && state == `PMICPS_ST_RUN)
        low_power_off_select <= low_power_off_wdata;
      // charger takes the inverse of the host disable bit once programmed in system-on
      if (backup_charger_wr && state == `PMICPS_ST_RUN)
        charger_on <= ~backup_charger_wdata;
      // self-test runs and retry spacing
      if (state == `PMICPS_ST_TEST && test_done) begin
        monitor_test_flag <= monitor_test_flag | monitor_test_fail;
        if (!(clock_in_tol && bandgaps_agree && mirror_crc_ok)) begin
          runs_r <= runs_r + 2'd1;
          if (runs_r + 2'd1 >= `PMICPS_SELF_TEST_RUNS)
            self_test_error <= 1'b1;
        end else begin
          runs_r <= 2'd0;
        end
      end
      if (state == `PMICPS_ST_WAIT) wait_r <= wait_r + 32'h1;
      else wait_r <= 32'h0;
      // accepted event: load defaults into functional registers
      if (state == `PMICPS_ST_QPOFF && state_nxt == `PMICPS_ST_PWRUP) begin
        switcher_run_voltage <= fuse_switcher_voltage;
        linear_run_voltage <= fuse_linear_voltage;
        switcher_seven_voltage <= fuse_switcher_seven_voltage;
        for (k = 0; k < NSW; k = k + 1)
          switcher_run_mode[k*2 +: 2] <= run_mode_default(
            fuse_switcher_in_seq[k], fuse_sync_input_enable,
            fuse_sync_output_enable, fuse_spread_spectrum_enable,
            fuse_switcher_mode);
        linear_run_enable <= fuse_linear_in_seq;
        slot_r <= 4'h0;
        step_cnt_r <= 32'h0;
      end
      // ordered enable sequence, one slot per step time
      if (state == `PMICPS_ST_PWRUP || state == `PMICPS_ST_RUN) begin
        if (step_cnt_r == STEP_CYC - 1) begin
          step_cnt_r <= 32'h0;
          if (slot_r != LAST_SLOT) slot_r <= slot_r + 4'h1;
        end else begin
          step_cnt_r <= step_cnt_r + 32'h1;
        end
        for (k = 0; k < NSW; k = k + 1)
          if (fuse_switcher_in_seq[k] && fuse_step_slot[k*4 +: 4] <= slot_r)
            switcher_enable[k] <= 1'b1;
        for (k = 0; k < NLDO; k = k + 1)
          if (fuse_linear_in_seq[k] &&
              fuse_step_slot[(NSW+k)*4 +: 4] <= slot_r)
            linear_enable[k] <= 1'b1;
        if (fuse_power_good_out_is_gpo && fuse_power_good_out_slot <= slot_r)
          power_good_out <= 1'b1;
        if (fuse_reset_slot <= slot_r)
          host_reset_out <= 1'b1;
      end
      if (state_nxt == `PMICPS_ST_RUN)
        host_reset_out <= 1'b1;
    end
  end
endmodule // pmicps_ctrl
`default_nettype wire

// >>> rtl/pmicps_regs.vh
// How it works
// - after both internal rails pass reset, copy fuses to mirror (and functional if selected).
// - crc mismatch on fuse load sets trim_load_error or fuse_load_error.
// - clean fuse load configures always-on supply, then goes to low power off.
// - low_power_off_select clears at supply rise; at 0 wait in low power off.
// - select at 1 and no event: move on to quick power-up off and wait.
// - event in low power off with select 0 and load error is ignored.
// - input below threshold with valid coin cell gives coin cell state.
// - self-test checks clock, bandgaps, mirror crc, and monitor built-in test.
// - failed self-test reruns up to 3 runs, 2.0 ms apart, then fail-safe.
// - failing monitor built-in test only sets a flag, never blocks.
// - passing self-test enters quick power-up off with circuits biased.
// - in quick power-up off with io supply, mirror registers are host accessible.
// - charger off in quick power-up off until host programs disable bit.
// - event in quick power-up off ignored while any load or test error set.
// - accepted event loads default configuration into functional registers.
// - power-up sequence enables regulators in order; power good may be a step.
// - host reset release is a programmable step; system-on follows the last step.
// - finished sequence enters run with host reset high.
// - switcher and linear run voltages load from fuse voltage bits.
// - seventh switcher uses one 5-bit voltage loaded from its fuse field.
// - switcher run mode default 01 for sync/spread, else from fuse mode; 00 off.
// - linear run enable defaults to 1 if in sequence, else 0.
// - power-up event is pin high in level mode or falling edge in edge mode.
// - self-test failure goes to fail-safe only when trial mode is off.
`ifndef PMICPS_REGS_VH
`define PMICPS_REGS_VH
`define PMICPS_CLK_MHZ 100
`define PMICPS_RETRY_US 2000
`define PMICPS_RETRY_CYC (`PMICPS_RETRY_US * `PMICPS_CLK_MHZ)
`define PMICPS_SELF_TEST_RUNS 3
`define PMICPS_MODE_OFF 2'b00
`define PMICPS_MODE_PWM 2'b01
`define PMICPS_MODE_AUTO 2'b11
`define PMICPS_ST_LOAD 4'h0
`define PMICPS_ST_LPOFF 4'h1
`define PMICPS_ST_TEST 4'h2
`define PMICPS_ST_WAIT 4'h3
`define PMICPS_ST_QPOFF 4'h4
`define PMICPS_ST_PWRUP 4'h5
`define PMICPS_ST_RUN 4'h6
`define PMICPS_ST_FSAFE 4'h7
`define PMICPS_ST_COIN 4'h8
`endif

// >>> rtl/pmicps_sync.v
`timescale 1ns/1ps
`default_nettype none
// three-stage input synchroniser; value updates when stages 2 and 3 agree
module pmicps_sync #(
  parameter W = 1
) (
  input wire clock,
  input wire srst,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer i;
  always @(posedge clock) begin
    if (srst) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          sync_out[i] <= s3_r[i];
        end
      end
    end
  end
endmodule // pmicps_sync
`default_nettype wire

// >>> rtl/pmicps_mirror.v
`timescale 1ns/1ps
`default_nettype none
// mirror register store; read data registered
module pmicps_mirror #(
  parameter AW = 5,
  parameter DW = 8
) (
  input wire clock,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // pmicps_mirror
`default_nettype wire

// >>> sim/pmicps_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// power state checker
// ----
module pmicps_chk #(
  parameter NSW = 7,
  parameter NLDO = 4
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [1:0] fuse_always_on_cfg,
  input wire logic fuse_sync_input_enable,
  input wire logic fuse_sync_output_enable,
  input wire logic fuse_spread_spectrum_enable,
  input wire logic fuse_switcher_mode,
  input wire logic [NSW*8-1:0] fuse_switcher_voltage,
  input wire logic [NLDO*4-1:0] fuse_linear_voltage,
  input wire logic [4:0] fuse_switcher_seven_voltage,
  input wire logic [NSW-1:0] fuse_switcher_in_seq,
  input wire logic [NLDO-1:0] fuse_linear_in_seq,
  input wire logic trial_config_mode,
  input wire logic [3:0] state,
  input wire logic trim_load_error,
  input wire logic fuse_load_error,
  input wire logic self_test_error,
  input wire logic [1:0] always_on_cfg,
  input wire logic low_power_off_select,
  input wire logic failsafe_req,
  input wire logic host_reset_out,
  input wire logic [NSW*8-1:0] switcher_run_voltage,
  input wire logic [NSW*2-1:0] switcher_run_mode,
  input wire logic [NLDO*4-1:0] linear_run_voltage,
  input wire logic [NLDO-1:0] linear_run_enable,
  input wire logic [4:0] switcher_seven_voltage
);
  logic [NSW*2-1:0] mode_exp;
  logic fast_mode;
  assign fast_mode = fuse_sync_input_enable | fuse_sync_output_enable |
    fuse_spread_spectrum_enable | fuse_switcher_mode;
  always_comb begin
    for (int k = 0; k < NSW; k++) begin
      mode_exp[2*k+:2] = !fuse_switcher_in_seq[k] ? 2'h0 :
        (fast_mode ? 2'h1 : 2'h3);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  property p_lp_refuse;
    state == 4'h1 && !low_power_off_select &&
      (trim_load_error || fuse_load_error) |=> state inside {4'h1, 4'h8};
  endproperty
  a_lp_refuse: assert property (p_lp_refuse)
    else $error("event taken in low power off despite load error");
  property p_qp_refuse;
    state == 4'h4 && (trim_load_error || fuse_load_error ||
      self_test_error) |=> state inside {4'h4, 4'h8};
  endproperty
  a_qp_refuse: assert property (p_qp_refuse)
    else $error("event taken in quick power-up off despite error");
  property p_run_reset;
    state == 4'h6 |-> host_reset_out;
  endproperty
  a_run_reset: assert property (p_run_reset)
    else $error("run state with host reset held");
  property p_rst_step;
    $rose(host_reset_out) |-> state inside {4'h5, 4'h6};
  endproperty
  a_rst_step: assert property (p_rst_step)
    else $error("host reset released outside power-up");
  property p_load_vsw;
    state == 4'h5 && $past(state) == 4'h4 |->
      switcher_run_voltage == fuse_switcher_voltage &&
      switcher_seven_voltage == fuse_switcher_seven_voltage;
  endproperty
  a_load_vsw: assert property (p_load_vsw)
    else $error("switcher voltages not loaded at power-up");
  property p_load_mode;
    state == 4'h5 && $past(state) == 4'h4 |-> switcher_run_mode == mode_exp;
  endproperty
  a_load_mode: assert property (p_load_mode)
    else $error("switcher mode default wrong");
  property p_load_ldo;
    state == 4'h5 && $past(state) == 4'h4 |->
      linear_run_enable == fuse_linear_in_seq &&
      linear_run_voltage == fuse_linear_voltage;
  endproperty
  a_load_ldo: assert property (p_load_ldo)
    else $error("linear defaults not loaded at power-up");
  property p_clean_load;
    state == 4'h1 && $past(state) == 4'h0 && !trim_load_error &&
      !fuse_load_error |-> ##[0:2] always_on_cfg == fuse_always_on_cfg;
  endproperty
  a_clean_load: assert property (p_clean_load)
    else $error("always-on supply not configured");
  property p_sel_reset;
    $past(srst) |-> !low_power_off_select;
  endproperty
  a_sel_reset: assert property (p_sel_reset)
    else $error("low power off select not cleared by reset");
  property p_fsafe;
    $rose(failsafe_req) |-> !trial_config_mode && self_test_error;
  endproperty
  a_fsafe: assert property (p_fsafe)
    else $error("fail-safe requested in trial mode");
endmodule // pmicps_chk
`default_nettype wire

// >>> sim/pmicps_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// host: boots after reset release, then picks quick power-up
// ----
module pmicps_host_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic host_reset_out,
  input wire logic [3:0] state,
  output logic low_power_off_wr,
  output logic low_power_off_wdata
);
  logic [3:0] boot_cnt_r;
  always @(posedge clock) begin
    if (srst || !host_reset_out || state != 4'h6) begin
      boot_cnt_r <= 4'h0;
      low_power_off_wr <= 1'h0;
      low_power_off_wdata <= 1'h0;
    end else begin
      if (boot_cnt_r != 4'hf)
        boot_cnt_r <= boot_cnt_r + 4'h1;
      // idle data line toggles so a stale value never looks written
      low_power_off_wr <= boot_cnt_r == 4'h7;
      low_power_off_wdata <= boot_cnt_r == 4'h7 ? 1'h1 : ~low_power_off_wdata;
    end
  end
endmodule // pmicps_host_model
`default_nettype wire

// >>> sim/test_pmicps_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmicps_regs.vh"
module test_pmicps_ctrl;
  // ----
  // stimulus and fixed fuse image
  // ----
  logic clock = 1'h0, srst = 1'h1, power_on_pin = 1'h0, fuse_crc_ok = 1'h1;
  logic digital_rail_ok = 1'h1, analog_rail_ok = 1'h1, input_above_uv = 1'h1;
  logic coin_cell_valid = 1'h1, fuse_program_supply = 1'h0, io_supply = 1'h1;
  logic fuse_trim_word_done = 1'h0, fuse_word_is_trim = 1'h0;
  logic fuse_load_done = 1'h1, fuse_power_on_mode = 1'h0, test_done = 1'h1;
  logic fuse_sync_input_enable = 1'h0, fuse_sync_output_enable = 1'h0;
  logic fuse_spread_spectrum_enable = 1'h0, fuse_switcher_mode = 1'h0;
  logic fuse_power_good_out_is_gpo = 1'h1, self_test_present = 1'h0;
  logic clock_in_tol = 1'h1, bandgaps_agree = 1'h1, mirror_crc_ok = 1'h1;
  logic trial_config_mode = 1'h0, backup_charger_wr = 1'h0, mirror_wr = 1'h0;
  logic backup_charger_wdata = 1'h0;
  logic [7:0] fuse_data = 8'h5a, mirror_wdata = 8'h00;
  logic [4:0] mirror_addr = 5'h00, fuse_switcher_seven_voltage = 5'h13;
  logic [1:0] fuse_always_on_cfg = 2'h2;
  logic [55:0] fuse_switcher_voltage = 56'h11223344556677;
  logic [15:0] fuse_linear_voltage = 16'h9abc;
  logic [6:0] fuse_switcher_in_seq = 7'h5b;
  logic [3:0] fuse_linear_in_seq = 4'h9, fuse_reset_slot = 4'h2;
  logic [3:0] fuse_power_good_out_slot = 4'h1, monitor_test_fail = 4'h5;
  logic [47:0] fuse_step_slot = 48'h0;
  logic low_power_off_wr, low_power_off_wdata, mirror_access_ok, ts_q;
  logic trim_load_error, fuse_load_error, self_test_error, fuse_to_functional;
  logic low_power_off_select, charger_on, internal_bias_on, test_start;
  logic failsafe_req, power_good_out, host_reset_out;
  logic [7:0] mirror_rdata;
  logic [4:0] switcher_seven_voltage;
  logic [1:0] always_on_cfg, md;
  logic [55:0] switcher_run_voltage;
  logic [15:0] linear_run_voltage;
  logic [13:0] switcher_run_mode;
  logic [6:0] switcher_enable;
  logic [3:0] state, monitor_test_flag, linear_enable, linear_run_enable;
  int fail_count = 0, n_checks = 0, starts = 0, k;

  pmicps_ctrl #(.RETRY_CYC(20), .STEP_CYC(4)) u_pmicps_ctrl (
    .clock, .srst, .digital_rail_ok, .analog_rail_ok, .input_above_uv,
    .coin_cell_valid, .power_on_pin, .fuse_program_supply, .io_supply,
    .fuse_data, .fuse_crc_ok, .fuse_trim_word_done, .fuse_word_is_trim,
    .fuse_load_done, .fuse_always_on_cfg, .fuse_power_on_mode,
    .fuse_sync_input_enable, .fuse_sync_output_enable,
    .fuse_spread_spectrum_enable, .fuse_switcher_mode,
    .fuse_switcher_voltage, .fuse_linear_voltage,
    .fuse_switcher_seven_voltage, .fuse_switcher_in_seq, .fuse_linear_in_seq,
    .fuse_step_slot, .fuse_reset_slot, .fuse_power_good_out_slot, .fuse_power_good_out_is_gpo,
    .self_test_present, .clock_in_tol, .bandgaps_agree, .mirror_crc_ok,
    .monitor_test_fail, .test_done, .trial_config_mode, .low_power_off_wr,
    .low_power_off_wdata, .backup_charger_wr, .backup_charger_wdata,
    .mirror_wr, .mirror_addr, .mirror_wdata, .mirror_rdata,
    .mirror_access_ok, .state, .trim_load_error, .fuse_load_error,
    .self_test_error, .monitor_test_flag, .fuse_to_functional,
    .always_on_cfg, .low_power_off_select, .charger_on, .internal_bias_on,
    .test_start, .failsafe_req, .switcher_enable, .linear_enable,
    .power_good_out, .host_reset_out, .switcher_run_voltage,
    .switcher_run_mode, .linear_run_voltage, .linear_run_enable,
    .switcher_seven_voltage);

  pmicps_host_model u_pmicps_host_model (.clock, .srst, .host_reset_out,
    .state, .low_power_off_wr, .low_power_off_wdata);

  initial begin
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    ts_q <= test_start;
    if (srst)
      starts <= 0;
    else if (test_start && !ts_q)
      starts <= starts + 1;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wait_st(input logic [3:0] s);
    int i;
    for (i = 0; i < 3000 && state !== s; i++) begin
      @(posedge clock);
      #1;
    end
    if (state !== s) begin
      fail_count++;
      $display("mismatch at %0t: state %0h not reached", $time, s);
      end_of_test;
    end
  endtask

  // reset then boot with chosen fuse crc, self-test and failing checks
  task automatic boot(input logic crc, st, tr, input logic [2:0] fl,
                      input logic [1:0] m);
    @(posedge clock);
    srst <= 1'h1;
    power_on_pin <= 1'h0;
    fuse_crc_ok <= crc;
    self_test_present <= st;
    trial_config_mode <= tr;
    clock_in_tol <= !fl[0];
    bandgaps_agree <= !fl[1];
    mirror_crc_ok <= !fl[2];
    fuse_switcher_mode <= m[0];
    fuse_spread_spectrum_enable <= m[1];
    repeat (10) @(posedge clock);
    srst <= 1'h0;
    wait_st(`PMICPS_ST_LPOFF);
    power_on_pin <= 1'h1;
  endtask

  function automatic logic [13:0] mode_exp(input logic [1:0] m);
    logic [13:0] r;
    for (int j = 0; j < 7; j++) begin
      r[2*j+:2] = !fuse_switcher_in_seq[j] ? 2'h0 : (m != 2'h0 ? 2'h1 : 2'h3);
    end
    return r;
  endfunction

  initial begin
    boot(1'h0, 1'h0, 1'h0, 3'h0, 2'h0);
    repeat (20) @(posedge clock);
    check(state, `PMICPS_ST_LPOFF);
    check({trim_load_error, fuse_load_error}, 2'h1);
    for (md = 2'h0; md < 2'h3; md++) begin
      boot(1'h1, 1'h0, 1'h0, 3'h0, md);
      check(always_on_cfg, 2'h2);
      check(low_power_off_select, 1'h0);
      wait_st(`PMICPS_ST_RUN);
      check({host_reset_out, power_good_out}, 2'h3);
      check(switcher_enable, 7'h5b);
      check({switcher_run_voltage[7:0], linear_run_voltage}, 24'h779abc);
      check(switcher_run_voltage, 56'h11223344556677);
      check(linear_run_voltage, 16'h9abc);
      check(switcher_seven_voltage, 5'h13);
      check(switcher_run_mode, mode_exp(md));
      check(linear_run_enable, 4'h9);
      repeat (14) @(posedge clock);
      check(low_power_off_select, 1'h1);
    end
    for (k = 0; k < 3; k++) begin
      boot(1'h1, 1'h1, 1'h1, 3'h1 << k, 2'h0);
      wait_st(`PMICPS_ST_QPOFF);
      repeat (40) @(posedge clock);
      check(state, `PMICPS_ST_QPOFF);
      check({self_test_error, starts[3:0]}, 5'h13);
    end
    boot(1'h1, 1'h1, 1'h0, 3'h2, 2'h0);
    wait_st(`PMICPS_ST_FSAFE);
    @(posedge clock);
    #1;
    check({failsafe_req, starts[3:0]}, 5'h13);
    boot(1'h1, 1'h1, 1'h0, 3'h0, 2'h0);
    wait_st(`PMICPS_ST_RUN);
    check({monitor_test_flag, starts[3:0]}, 8'h51);
    input_above_uv <= 1'h0;
    repeat (10) @(posedge clock);
    check(state, `PMICPS_ST_COIN);
    end_of_test;
  end
endmodule // test_pmicps_ctrl

bind pmicps_ctrl pmicps_chk #(.NSW(NSW), .NLDO(NLDO)) u_pmicps_chk (
  .clock, .srst, .fuse_always_on_cfg, .fuse_sync_input_enable,
  .fuse_sync_output_enable, .fuse_spread_spectrum_enable,
  .fuse_switcher_mode, .fuse_switcher_voltage, .fuse_linear_voltage,
  .fuse_switcher_seven_voltage, .fuse_switcher_in_seq, .fuse_linear_in_seq,
  .trial_config_mode, .state, .trim_load_error, .fuse_load_error,
  .self_test_error, .always_on_cfg, .low_power_off_select, .failsafe_req,
  .host_reset_out, .switcher_run_voltage, .switcher_run_mode,
  .linear_run_voltage, .linear_run_enable, .switcher_seven_voltage);
`default_nettype wire
